// *** shared/sfe_params.svh ***
// opcodes, field positions and timing counts for the serial flash instruction front end
`ifndef SFE_PARAMS_SVH
`define SFE_PARAMS_SVH

`define SFE_OP_SET_LATCH          8'h06
`define SFE_OP_CLR_LATCH          8'h04
`define SFE_OP_IDENT_FETCH        8'h9F
`define SFE_OP_IDENT_FETCH_SHORT  8'h9E
`define SFE_OP_STATUS_FETCH       8'h05
`define SFE_OP_STATUS_STORE       8'h01
`define SFE_OP_LOCK_STORE         8'hE5
`define SFE_OP_LOCK_FETCH         8'hE8
`define SFE_OP_READ               8'h03
`define SFE_OP_FAST_READ          8'h0B
`define SFE_OP_TWO_LANE_FETCH     8'h3B
`define SFE_OP_OTP_FETCH          8'h4B
`define SFE_OP_OTP_BURN           8'h42
`define SFE_OP_PAGE_WRITE         8'h02
`define SFE_OP_TWO_LANE_PAGE      8'hA2
`define SFE_OP_SMALL_ERASE        8'h20
`define SFE_OP_WIDE_WIPE          8'hD8
`define SFE_OP_CHIP_WIPE          8'hC7
`define SFE_OP_DEEP_SLEEP         8'hB9
`define SFE_OP_WAKE               8'hAB

`define SFE_ST_BUSY_BIT           0
`define SFE_ST_LATCH_BIT          1

`define SFE_NO_LIMIT              9'h000
`define SFE_ONE_BYTE              9'h001
`define SFE_IDENT_SHORT_MAX       9'h003
`define SFE_IDENT_MAX             9'h014
`define SFE_OTP_MAX               9'h041
`define SFE_PAGE_MAX              9'h100

`define SFE_CLK_PERIOD_NS         10
`define SFE_WRITE_CYCLE_NS        5000
`define SFE_WRITE_CYCLES ((`SFE_WRITE_CYCLE_NS + `SFE_CLK_PERIOD_NS - 1) / `SFE_CLK_PERIOD_NS)

`endif

// *** shared/sfe_pkg.sv ***
// types for the serial flash instruction front end
package sfe_pkg;

    typedef enum logic [4:0] {
        SFE_K_NONE, SFE_K_SET_LATCH, SFE_K_CLR_LATCH, SFE_K_IDENT_FETCH,
        SFE_K_STATUS_FETCH, SFE_K_STATUS_STORE, SFE_K_LOCK_STORE, SFE_K_LOCK_FETCH,
        SFE_K_READ, SFE_K_FAST_READ, SFE_K_TWO_LANE_FETCH, SFE_K_OTP_FETCH,
        SFE_K_OTP_BURN, SFE_K_PAGE_WRITE, SFE_K_TWO_LANE_PAGE, SFE_K_SMALL_ERASE,
        SFE_K_WIDE_WIPE, SFE_K_CHIP_WIPE, SFE_K_DEEP_SLEEP, SFE_K_WAKE
    } sfe_kind_t;

    typedef enum logic [1:0] {
        SFE_PH_OPCODE = 2'h0,
        SFE_PH_ADDR   = 2'h1,
        SFE_PH_DUMMY  = 2'h3,
        SFE_PH_DATA   = 2'h2
    } sfe_phase_t;

    typedef struct packed {
        logic       known;
        sfe_kind_t  kind;
        logic [1:0] addr_n;
        logic       dummy;
        logic       reads;
        logic       dual_out;
        logic       dual_in;
        logic       framed;
        logic       needs_latch;
        logic       long_cycle;
        logic [8:0] min_data;
        logic [8:0] max_data;
    } sfe_cmd_t;

    typedef struct packed {
        logic        tog;
        logic [7:0]  op;
        logic [8:0]  bytes;
        logic [2:0]  mod;
        logic [23:0] addr;
        logic [7:0]  data;
    } sfe_res_t;

    typedef struct packed {
        logic sleep;
        logic latch;
        logic busy;
    } sfe_flags_t;

endpackage : sfe_pkg

// *** rtl/sfe_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/10ps
module sfe_sync #(
    parameter int W = 1
) (
    // clock and reset of the receiving domain
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // level in and synchronised level out
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] stage1;

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            stage1 <= '0;
            o_q    <= '0;
        end
        else
        begin
            stage1 <= i_d;
            o_q    <= stage1;
        end
    end
endmodule : sfe_sync

// *** rtl/sfe_decode.sv ***
// opcode to instruction shape lookup
`timescale 1ns/10ps
`include "sfe_params.svh"
module sfe_decode
    import sfe_pkg::*;
(
    // opcode in, shape out
    input  wire logic [7:0] i_op,
    output sfe_cmd_t        o_cmd
);
    // flags order: reads, dual_out, dual_in, framed, needs_latch, long_cycle
    function automatic sfe_cmd_t mk(input sfe_kind_t k, input logic [1:0] an,
                                    input logic dm, input logic [5:0] fl,
                                    input logic [8:0] mn, input logic [8:0] mx);
        sfe_cmd_t c;
        c = '{1'b1, k, an, dm, fl[5], fl[4], fl[3], fl[2], fl[1], fl[0], mn, mx};
        return c;
    endfunction : mk

    always_comb
    begin
        o_cmd = '0;
        unique case (i_op)
            `SFE_OP_SET_LATCH:         o_cmd = mk(SFE_K_SET_LATCH, 2'h0, 1'h0, 6'h04, 9'h000, 9'h000);
            `SFE_OP_CLR_LATCH:         o_cmd = mk(SFE_K_CLR_LATCH, 2'h0, 1'h0, 6'h04, 9'h000, 9'h000);
            `SFE_OP_IDENT_FETCH:       o_cmd = mk(SFE_K_IDENT_FETCH, 2'h0, 1'h0, 6'h20, 9'h000, `SFE_IDENT_MAX);
            `SFE_OP_IDENT_FETCH_SHORT: o_cmd = mk(SFE_K_IDENT_FETCH, 2'h0, 1'h0, 6'h20, 9'h000, `SFE_IDENT_SHORT_MAX);
            `SFE_OP_STATUS_FETCH:      o_cmd = mk(SFE_K_STATUS_FETCH, 2'h0, 1'h0, 6'h20, 9'h000, `SFE_NO_LIMIT);
            `SFE_OP_STATUS_STORE:      o_cmd = mk(SFE_K_STATUS_STORE, 2'h0, 1'h0, 6'h07, `SFE_ONE_BYTE, `SFE_ONE_BYTE);
            `SFE_OP_LOCK_STORE:        o_cmd = mk(SFE_K_LOCK_STORE, 2'h3, 1'h0, 6'h06, `SFE_ONE_BYTE, `SFE_ONE_BYTE);
            `SFE_OP_LOCK_FETCH:        o_cmd = mk(SFE_K_LOCK_FETCH, 2'h3, 1'h0, 6'h20, 9'h000, `SFE_ONE_BYTE);
            `SFE_OP_READ:              o_cmd = mk(SFE_K_READ, 2'h3, 1'h0, 6'h20, 9'h000, `SFE_NO_LIMIT);
            `SFE_OP_FAST_READ:         o_cmd = mk(SFE_K_FAST_READ, 2'h3, 1'h1, 6'h20, 9'h000, `SFE_NO_LIMIT);
            `SFE_OP_TWO_LANE_FETCH:    o_cmd = mk(SFE_K_TWO_LANE_FETCH, 2'h3, 1'h1, 6'h30, 9'h000, `SFE_NO_LIMIT);
            `SFE_OP_OTP_FETCH:         o_cmd = mk(SFE_K_OTP_FETCH, 2'h3, 1'h1, 6'h20, 9'h000, `SFE_OTP_MAX);
            `SFE_OP_OTP_BURN:          o_cmd = mk(SFE_K_OTP_BURN, 2'h3, 1'h0, 6'h07, `SFE_ONE_BYTE, `SFE_OTP_MAX);
            `SFE_OP_PAGE_WRITE:        o_cmd = mk(SFE_K_PAGE_WRITE, 2'h3, 1'h0, 6'h07, `SFE_ONE_BYTE, `SFE_PAGE_MAX);
            `SFE_OP_TWO_LANE_PAGE:     o_cmd = mk(SFE_K_TWO_LANE_PAGE, 2'h3, 1'h0, 6'h0F, `SFE_ONE_BYTE, `SFE_PAGE_MAX);
            `SFE_OP_SMALL_ERASE:       o_cmd = mk(SFE_K_SMALL_ERASE, 2'h3, 1'h0, 6'h07, 9'h000, 9'h000);
            `SFE_OP_WIDE_WIPE:         o_cmd = mk(SFE_K_WIDE_WIPE, 2'h3, 1'h0, 6'h07, 9'h000, 9'h000);
            `SFE_OP_CHIP_WIPE:         o_cmd = mk(SFE_K_CHIP_WIPE, 2'h0, 1'h0, 6'h07, 9'h000, 9'h000);
            `SFE_OP_DEEP_SLEEP:        o_cmd = mk(SFE_K_DEEP_SLEEP, 2'h0, 1'h0, 6'h04, 9'h000, 9'h000);
            `SFE_OP_WAKE:              o_cmd = mk(SFE_K_WAKE, 2'h0, 1'h0, 6'h00, 9'h000, 9'h000);
            default:                   o_cmd = '0;
        endcase
    end
endmodule : sfe_decode

// *** rtl/sfe_front_end.sv ***
// serial flash instruction front end: link framing, decode and write-permit control
`timescale 1ns/10ps
`include "sfe_params.svh"

module sfe_front_end
    import sfe_pkg::*;
#(
    parameter int WRITE_CYCLES = `SFE_WRITE_CYCLES
) (
    // system clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // serial link pins
    input  wire logic        i_sclk,
    input  wire logic        i_cs_n,
    input  wire logic        i_serial_in_lane0,
    input  wire logic        i_serial_out_lane1,
    output logic             o_serial_in_lane0,
    output logic             o_serial_in_lane0_oe,
    output logic             o_serial_out_lane1,
    output logic             o_serial_out_lane1_oe,
    // array side, serial clock domain
    input  wire logic [7:0]  i_array_byte,
    output logic      [23:0] o_fetch_addr,
    output logic             o_fetch_active,
    output logic      [7:0]  o_wr_byte,
    output logic             o_wr_byte_valid,
    // accepted instructions, system clock domain
    output logic             o_exec_valid,
    output sfe_kind_t        o_exec_kind,
    output logic      [23:0] o_exec_addr,
    output logic      [7:0]  o_exec_data,
    output logic      [8:0]  o_exec_len,
    output logic             o_frame_reject,
    // device state, system clock domain
    output logic             o_write_busy_flag,
    output logic             o_write_permit_latch,
    output logic             o_deep_sleep
);
    typedef struct packed {
        sfe_phase_t  phase;
        logic        started;
        logic [2:0]  bit_cnt;
        logic [7:0]  shift;
        logic [7:0]  op;
        logic [1:0]  addr_left;
        logic [8:0]  data_cnt;
        logic [23:0] addr;
        logic        sending;
        logic        fetching;
        logic        dual_out;
        logic        dual_in;
        logic [7:0]  wr_byte;
        logic        wr_valid;
    } sfe_link_t;

    typedef struct packed {
        logic [7:0] tx;
        logic       lane1;
        logic       lane0;
        logic       oe1;
        logic       oe0;
    } sfe_drive_t;

    typedef struct packed {
        logic        cs_prev;
        logic        last_tog;
        logic        latch;
        logic        busy;
        logic [15:0] busy_cnt;
        logic        sleep;
        logic        exec_valid;
        sfe_kind_t   exec_kind;
        logic [23:0] exec_addr;
        logic [7:0]  exec_data;
        logic [8:0]  exec_len;
        logic        reject;
    } sfe_sys_t;

    sfe_link_t  lk;
    sfe_link_t  next_lk;
    sfe_res_t   res;
    sfe_res_t   next_res;
    sfe_drive_t dr;
    sfe_drive_t next_dr;
    sfe_sys_t   sy;
    sfe_sys_t   next_sy;

    sfe_cmd_t   cmd;
    sfe_cmd_t   res_cmd;
    sfe_flags_t flags_s;
    logic       cs_s;
    logic [7:0] in_bits;
    logic [7:0] op_in;
    logic       lk_dual;
    logic [3:0] bit_sum;
    logic [7:0] src_byte;

    // ---------------- serial clock domain ----------------

    sfe_sync #(
        .W(3)
    ) u_flag_sync (
        .i_clk (i_sclk),
        .i_rst (1'b0),
        .i_d   ({sy.sleep, sy.latch, sy.busy}),
        .o_q   (flags_s)
    );

    assign lk_dual = (lk.phase == SFE_PH_DATA) && (lk.dual_in || (lk.dual_out && lk.sending));
    assign bit_sum = {1'b0, lk.bit_cnt} + (lk_dual ? 4'h2 : 4'h1);
    // lane1 carries the higher bit of each pair in two-lane input
    assign in_bits = (lk.phase == SFE_PH_DATA && lk.dual_in)
                   ? {lk.shift[5:0], i_serial_out_lane1, i_serial_in_lane0}
                   : {lk.shift[6:0], i_serial_in_lane0};
    assign op_in   = (lk.phase == SFE_PH_OPCODE) ? in_bits : lk.op;

    sfe_decode u_link_decode (
        .i_op  (op_in),
        .o_cmd (cmd)
    );

    always_comb
    begin
        logic       go_data;
        logic       gate;
        logic       more;
        logic       stream;
        logic [8:0] cnt_inc;
        go_data  = 1'b0;
        cnt_inc  = (lk.data_cnt == 9'h1FF) ? lk.data_cnt : lk.data_cnt + 9'h001;
        more     = (cmd.max_data == `SFE_NO_LIMIT) || (cnt_inc < cmd.max_data);
        // status stays readable during a write cycle, the array does not
        gate     = ~flags_s.sleep && ((cmd.kind == SFE_K_STATUS_FETCH) || ~flags_s.busy);
        stream   = cmd.long_cycle && (cmd.addr_n != 2'h0) && (cmd.max_data != 9'h000);
        next_lk  = lk;
        next_res = res;
        next_lk.shift    = in_bits;
        next_lk.bit_cnt  = bit_sum[2:0];
        next_lk.started  = 1'b1;
        next_lk.wr_valid = 1'b0;
        // a fresh toggle tells the system side that this frame saw clock edges
        next_res.tog   = lk.started ? res.tog : ~res.tog;
        next_res.mod   = bit_sum[2:0];
        next_res.bytes = lk.started ? res.bytes : 9'h000;
        if (bit_sum[3])
        begin
            if (next_res.bytes != 9'h1FF)
            begin
                next_res.bytes = next_res.bytes + 9'h001;
            end
            unique case (lk.phase)
                SFE_PH_OPCODE:
                begin
                    next_lk.op  = in_bits;
                    next_res.op = in_bits;
                    if (cmd.addr_n != 2'h0)
                    begin
                        next_lk.phase     = SFE_PH_ADDR;
                        next_lk.addr_left = cmd.addr_n - 2'h1;
                    end
                    else
                    begin
                        go_data = 1'b1;
                    end
                end
                SFE_PH_ADDR:
                begin
                    next_lk.addr      = {lk.addr[15:0], in_bits};
                    next_lk.addr_left = lk.addr_left - 2'h1;
                    if (lk.addr_left == 2'h0)
                    begin
                        if (cmd.dummy)
                        begin
                            next_lk.phase = SFE_PH_DUMMY;
                        end
                        else
                        begin
                            go_data = 1'b1;
                        end
                    end
                end
                SFE_PH_DUMMY:
                begin
                    go_data = 1'b1;
                end
                SFE_PH_DATA:
                begin
                    next_lk.data_cnt = cnt_inc;
                    if (lk.data_cnt == 9'h000)
                    begin
                        next_res.data = in_bits;
                    end
                    if (lk.sending)
                    begin
                        next_lk.addr    = lk.addr + 24'h000001;
                        next_lk.sending = more;
                        next_lk.fetching = more && lk.fetching;
                    end
                    // program data streams out only while writes are permitted
                    next_lk.wr_byte  = in_bits;
                    next_lk.wr_valid = stream && flags_s.latch && gate
                                       && (lk.data_cnt < cmd.max_data);
                end
            endcase
        end
        if (go_data)
        begin
            next_lk.phase    = SFE_PH_DATA;
            next_lk.data_cnt = 9'h000;
            next_lk.sending  = cmd.reads && gate;
            // status polling is not an array access, so it never raises the fetch strobe
            next_lk.fetching = cmd.reads && gate && (cmd.kind != SFE_K_STATUS_FETCH);
            next_lk.dual_out = cmd.dual_out;
            next_lk.dual_in  = cmd.dual_in;
        end
        next_res.addr = next_lk.addr;
    end

    // deselect clears the frame at once: the serial clock may already have stopped
    always_ff @(posedge i_sclk or posedge i_cs_n)
    begin
        if (i_cs_n)
        begin
            lk <= '0;
        end
        else
        begin
            lk <= next_lk;
        end
    end

    // the frame summary survives deselect so the system side can judge it
    always_ff @(posedge i_sclk or posedge i_srst)
    begin
        if (i_srst)
        begin
            res <= '0;
        end
        else if (!i_cs_n)
        begin
            res <= next_res;
        end
    end

    always_comb
    begin
        logic [7:0] cur;
        src_byte = i_array_byte;
        if (lk.op == `SFE_OP_STATUS_FETCH)
        begin
            src_byte = 8'h00;
            src_byte[`SFE_ST_BUSY_BIT]  = flags_s.busy;
            src_byte[`SFE_ST_LATCH_BIT] = flags_s.latch;
        end
        cur     = (lk.bit_cnt == 3'h0) ? src_byte : dr.tx;
        next_dr = '0;
        if (lk.sending)
        begin
            next_dr.tx    = cur;
            next_dr.lane1 = cur[3'h7 - lk.bit_cnt];
            next_dr.lane0 = lk.dual_out ? cur[3'h6 - lk.bit_cnt] : 1'b0;
            next_dr.oe1   = 1'b1;
            next_dr.oe0   = lk.dual_out;
        end
    end

    // output bits change on the falling edge; deselect floats them after any bit
    always_ff @(negedge i_sclk or posedge i_cs_n)
    begin
        if (i_cs_n)
        begin
            dr <= '0;
        end
        else
        begin
            dr <= next_dr;
        end
    end

    assign o_serial_out_lane1    = dr.lane1;
    assign o_serial_out_lane1_oe = dr.oe1;
    assign o_serial_in_lane0     = dr.lane0;
    assign o_serial_in_lane0_oe  = dr.oe0;
    assign o_fetch_addr          = lk.addr;
    assign o_fetch_active        = lk.fetching;
    assign o_wr_byte             = lk.wr_byte;
    assign o_wr_byte_valid       = lk.wr_valid;

    // ---------------- system clock domain ----------------

    sfe_sync #(
        .W(1)
    ) u_cs_sync (
        .i_clk (i_clk),
        .i_rst (i_srst),
        .i_d   (i_cs_n),
        .o_q   (cs_s)
    );

    // res is read only after the synchronised deselect, when it cannot change
    sfe_decode u_sys_decode (
        .i_op  (res.op),
        .o_cmd (res_cmd)
    );

    always_comb
    begin
        logic [8:0] hdr;
        logic [8:0] dbytes;
        logic       len_ok;
        logic       frame_ok;
        hdr      = 9'h001 + {7'h00, res_cmd.addr_n} + {8'h00, res_cmd.dummy};
        dbytes   = res.bytes - hdr;
        len_ok   = (res.bytes >= hdr) && (dbytes >= res_cmd.min_data)
                   && ((res_cmd.max_data == 9'h000) || (dbytes <= res_cmd.max_data));
        frame_ok = res_cmd.known && (res.mod == 3'h0) && len_ok;
        next_sy            = sy;
        next_sy.cs_prev    = cs_s;
        next_sy.exec_valid = 1'b0;
        next_sy.reject     = 1'b0;
        if (sy.busy)
        begin
            if (sy.busy_cnt == 16'h0000)
            begin
                next_sy.busy  = 1'b0;
                next_sy.latch = 1'b0;
            end
            else
            begin
                next_sy.busy_cnt = sy.busy_cnt - 16'h0001;
            end
        end
        if (cs_s && !sy.cs_prev && (res.tog != sy.last_tog))
        begin
            next_sy.last_tog = res.tog;
            if (res_cmd.kind == SFE_K_WAKE)
            begin
                next_sy.sleep = 1'b0;
            end
            else if (res_cmd.framed && !frame_ok)
            begin
                next_sy.reject = 1'b1;
            end
            else if (res_cmd.framed && !sy.busy && !sy.sleep)
            begin
                unique case (res_cmd.kind)
                    SFE_K_SET_LATCH:  next_sy.latch = 1'b1;
                    SFE_K_CLR_LATCH:  next_sy.latch = 1'b0;
                    SFE_K_DEEP_SLEEP: next_sy.sleep = 1'b1;
                    default:
                    begin
                        if (sy.latch)
                        begin
                            next_sy.exec_valid = 1'b1;
                            next_sy.exec_kind  = res_cmd.kind;
                            next_sy.exec_addr  = res.addr;
                            next_sy.exec_data  = res.data;
                            next_sy.exec_len   = dbytes;
                            if (res_cmd.long_cycle)
                            begin
                                next_sy.busy     = 1'b1;
                                next_sy.busy_cnt = 16'(WRITE_CYCLES - 1);
                            end
                            else
                            begin
                                next_sy.latch = 1'b0;
                            end
                        end
                        else
                        begin
                            next_sy.reject = 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            sy <= '0;
        end
        else
        begin
            sy <= next_sy;
        end
    end

    assign o_exec_valid         = sy.exec_valid;
    assign o_exec_kind          = sy.exec_kind;
    assign o_exec_addr          = sy.exec_addr;
    assign o_exec_data          = sy.exec_data;
    assign o_exec_len           = sy.exec_len;
    assign o_frame_reject       = sy.reject;
    assign o_write_busy_flag    = sy.busy;
    assign o_write_permit_latch = sy.latch;
    assign o_deep_sleep         = sy.sleep;

endmodule : sfe_front_end

// *** tb/sfe_host_model.sv ***
// spi host model; sclk idles low between frames
`timescale 1ns/10ps
module sfe_host_model (
    // link pins
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_lane0,
    output logic      o_lane1,
    // lane the device answers on
    input  wire logic i_lane1
);
    logic [7:0] rx [$];
    // a clean rising select edge clears the device's link logic at start
    initial
    begin
        {o_sclk, o_cs_n, o_lane0, o_lane1} = 4'h0;
        #1 o_cs_n = 1'b1;
    end
    // past the given bytes the lanes toggle: a released lane holds no value
    task automatic frame(input logic [7:0] tx [$], input int n);
        logic [7:0] sh;
        rx.delete();
        #3 o_cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            o_lane0 = (i < 8 * tx.size()) ? tx[i / 8][7 - i % 8] : ~o_lane0;
            o_lane1 = ~o_lane1;
            #7.5 o_sclk = 1'b1;
            sh = {sh[6:0], i_lane1};
            if (i % 8 == 7)
                rx.push_back(sh);
            #7.5 o_sclk = 1'b0;
        end
        #5 o_cs_n = 1'b1;
    endtask : frame
endmodule : sfe_host_model

// *** tb/sfe_checker.sv ***
// port assertions for the instruction front end
`timescale 1ns/10ps
module sfe_checker
    import sfe_pkg::*;
#(
    parameter int WRITE_CYCLES = 20
) (
    // clock and resets
    input wire logic      i_clk,
    input wire logic      i_srst,
    input wire logic      i_cs_n,
    // watched outputs
    input wire logic      o_serial_out_lane1_oe,
    input wire logic      o_fetch_active,
    input wire logic      o_exec_valid,
    input wire sfe_kind_t o_exec_kind,
    input wire logic      o_frame_reject,
    input wire logic      o_write_busy_flag,
    input wire logic      o_write_permit_latch
);
    localparam int BUSY_MAX = WRITE_CYCLES + 2;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    exec_pulse_a: assert property (o_exec_valid |=> !o_exec_valid)
        else $error("exec pulse long");
    exec_latch_a: assert property (o_exec_valid |-> $past(o_write_permit_latch))
        else $error("exec without latch");
    reject_excl_a: assert property (o_frame_reject |-> !o_exec_valid)
        else $error("reject with exec");
    busy_start_a: assert property (o_exec_valid && o_exec_kind == SFE_K_STATUS_STORE |=>
        o_write_busy_flag [*8]) else $error("busy missing");
    busy_end_a: assert property ($rose(o_write_busy_flag) |->
        ##[1:BUSY_MAX] !o_write_busy_flag) else $error("busy stuck");
    latch_drop_a: assert property ($fell(o_write_busy_flag) |-> ##[0:1] !o_write_permit_latch)
        else $error("latch kept");
    oe_release_a: assert property (i_cs_n [*2] |-> !o_serial_out_lane1_oe)
        else $error("lane driven");
    busy_array_a: assert property (o_write_busy_flag |-> !o_fetch_active)
        else $error("fetch while busy");
    cover property (o_exec_valid);
    cover property (o_frame_reject);
    cover property ($fell(o_write_busy_flag));
endmodule : sfe_checker
bind sfe_front_end sfe_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.i_clk, .i_srst, .i_cs_n,
    .o_serial_out_lane1_oe, .o_fetch_active, .o_exec_valid, .o_exec_kind, .o_frame_reject,
    .o_write_busy_flag, .o_write_permit_latch);

// *** tb/sfe_front_end_tb_top.sv ***
// self-checking bench for the instruction front end
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
module sfe_front_end_tb_top;
    import sfe_pkg::*;
    logic        i_clk = 1'b0;
    // reset rises after time zero so the link-side summary sees a real edge
    logic        i_srst = 1'b0;
    logic        sclk, cs_n, h0, h1, lane0, lane1, d0, d0_oe, d1, d1_oe, busy, latch;
    logic        rej, wv, slp;
    logic [7:0]  wb;
    logic [7:0]  wb_last = 8'h00;
    logic [8:0]  el;
    logic [3:0]  rej_n = 4'h0;
    logic [23:0] fa, ea;
    logic [7:0]  ed;
    sfe_kind_t   ek;
    int          error_cnt = 0;
    int          samples_checked = 0;
    assign lane0 = d0_oe ? d0 : h0;
    assign lane1 = d1_oe ? d1 : h1;
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk)
        rej_n <= rej_n + {3'h0, rej};
    // program bytes stand one serial clock, so catch them on the falling edge
    always @(negedge sclk)
        if (wv)
            wb_last <= wb;
    sfe_front_end #(.WRITE_CYCLES(200)) dut (.i_clk, .i_srst, .i_sclk(sclk), .i_cs_n(cs_n),
        .i_serial_in_lane0(lane0), .i_serial_out_lane1(lane1), .o_serial_in_lane0(d0),
        .o_serial_in_lane0_oe(d0_oe), .o_serial_out_lane1(d1), .o_serial_out_lane1_oe(d1_oe),
        .i_array_byte(fa[7:0] ^ 8'hA5), .o_fetch_addr(fa), .o_fetch_active(), .o_wr_byte(wb),
        .o_wr_byte_valid(wv), .o_exec_valid(), .o_exec_kind(ek), .o_exec_addr(ea),
        .o_exec_data(ed), .o_exec_len(el), .o_frame_reject(rej), .o_write_busy_flag(busy),
        .o_write_permit_latch(latch), .o_deep_sleep(slp));
    sfe_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_lane0(h0), .o_lane1(h1),
        .i_lane1(lane1));
    task automatic op(input logic [7:0] q [$], input int n);
        host.frame(q, n);
        repeat (6) @(posedge i_clk);
        #1;
    endtask : op
    task automatic t_latch();
        op('{8'h06}, 8);
        `CHK("latch", 1'h1, latch)
        op('{8'h05}, 27);
        `CHK("status", 8'h02, host.rx[1])
        `CHK("status repeat", 8'h02, host.rx[2])
        op('{8'h04}, 8);
        `CHK("latch clear", 1'h0, latch)
        op('{8'h06}, 12);
        `CHK("short frame", 1'h0, latch)
        `CHK("reject", 4'h1, rej_n)
        op('{8'hB9}, 8);
        `CHK("sleep", 1'h1, slp)
        op('{8'hAB}, 8);
        `CHK("wake", 1'h0, slp)
    endtask : t_latch
    task automatic t_write();
        op('{8'h06}, 8);
        op('{8'h01, 8'h3C}, 16);
        `CHK("kind", SFE_K_STATUS_STORE, ek)
        `CHK("data", 8'h3C, ed)
        `CHK("busy", 1'h1, busy)
        op('{8'h03, 8'h00, 8'h00, 8'h00}, 48);
        op('{8'h05}, 16);
        `CHK("status busy", 8'h03, host.rx[1])
        for (int i = 0; i < 300 && busy; i++)
            #10;
        #20;
        `CHK("done", 2'h0, {busy, latch})
    endtask : t_write
    task automatic t_read();
        logic [7:0] rd [2] = '{8'h03, 8'h0B};
        for (int k = 0; k < 2; k++)
        begin
            op('{rd[k], 8'h00, 8'h01, 8'hFE}, 48 + 8 * k);
            `CHK("first data", 8'h5B, host.rx[4 + k])
            `CHK("next data", 8'h5A, host.rx[5 + k])
        end
        op('{8'h03, 8'h00, 8'h00, 8'h00}, 35);
        op('{8'h06}, 8);
        `CHK("after cut read", 1'h1, latch)
    endtask : t_read
    task automatic t_lock();
        op('{8'hE5, 8'h12, 8'h34, 8'h56, 8'h80}, 40);
        `CHK("lock kind", SFE_K_LOCK_STORE, ek)
        `CHK("lock addr", 24'h123456, ea)
        `CHK("lock latch", 2'h0, {busy, latch})
        op('{8'h01, 8'h00}, 16);
        `CHK("no latch", 1'h0, busy)
        `CHK("reject count", 4'h2, rej_n)
        op('{8'h06}, 8);
        op('{8'h42, 8'h00, 8'h00, 8'h10, 8'hC3, 8'h3C}, 48);
        `CHK("otp kind", SFE_K_OTP_BURN, ek)
        `CHK("otp len", 9'h002, el)
        `CHK("otp data", 8'hC3, ed)
        `CHK("program byte", 8'h3C, wb_last)
    endtask : t_lock
    initial
    begin
        #1 i_srst = 1'b1;
        repeat (10) @(posedge i_clk);
        #1 i_srst = 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        t_latch();
        t_write();
        t_read();
        t_lock();
        results();
    end
    initial
    begin
        #100000;
        error_cnt++;
        results();
    end
    task automatic results();
        if (error_cnt == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
endmodule : sfe_front_end_tb_top
